// *** tsc_pkg.sv ***
package tsc_pkg;

  localparam logic [6:0] ADDR_LO = 7'h48;
  localparam logic [6:0] ADDR_HI = 7'h49;

  localparam logic [1:0] CR_WRITE = 2'h0;
  localparam logic [1:0] CR_READ = 2'h1;

  localparam logic [3:0] CMD_SELECT = 4'ha;
  localparam logic [3:0] CMD_CONVERT = 4'hb;
  localparam logic [3:0] CMD_MAN = 4'hc;
  localparam logic [3:0] CMD_PEN_DETECT_MODE_CMD = 4'hd;
  localparam logic [3:0] CMD_PEN_TRIGGER_MODE_CMD = 4'he;

  localparam logic [2:0] CH_X = 3'h0;
  localparam logic [2:0] CH_SEQ = 3'h7;

  localparam logic [5:0] REG_CHAN_MASK = 6'h04;
  localparam int REG_COUNT = 64;

  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [15:0] INVALID_WORD = 16'hffff;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SEEN = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_RXACK = 3'h2,
    ST_TX = 3'h3,
    ST_TXACK = 3'h4
  } tsc_state_e;

  typedef enum logic [2:0] {
    PH_ADDR = 3'h0,
    PH_CTRL = 3'h1,
    PH_PTR = 3'h2,
    PH_DATA = 3'h3,
    PH_IGN = 3'h4
  } tsc_phase_e;

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'h0,
    MODE_PEN_DETECT_MODE_CMD = 2'h1,
    MODE_PEN_TRIGGER_MODE_CMD = 2'h2
  } tsc_mode_e;

  // One converter result; last marks the end of an acquisition frame.
  typedef struct packed {
    logic valid;
    logic last;
    logic [1:0] chan;
    logic penUp;
    logic [11:0] data;
  } tsc_sample_s;

  typedef struct packed {
    logic select;
    logic convert;
    logic [2:0] chan;
  } tsc_cmd_s;

  function automatic logic [7:0] tsc_reg_default(input int idx);
    case (idx)
      1: tsc_reg_default = 8'h20;
      4: tsc_reg_default = 8'hc0;
      8: tsc_reg_default = 8'h80;
      32: tsc_reg_default = 8'h01;
      34: tsc_reg_default = 8'h08;
      default: tsc_reg_default = 8'h00;
    endcase
  endfunction

endpackage

// *** tsc_i2c_slave.sv ***
// Notes on behaviour
// - Register read: write address, control 01, pointer.
// - Repeated start, read address, device sends data.
// - Pointer advances after each returned byte.
// - Hold clock low after last command bit.
// - Touch command: address, one byte, stop.
// - 1010x selects, 1011x converts given channel.
// - 1100, 1101, 1110 enter the three modes.
// - Channel codes: X, Y, pressures, masked sequence.
// - Direct read address returns two bytes per channel.
// - Mask or manual convert picks channels, max four.
// - Stop after last valid data releases alert.
// - Converter suspended while alert low.
// - Channel read stretches right after address byte.
// - Channels returned X, Y, first, second pressure.
// - Each word carries two-bit channel tag.
// - Each word carries twelve-bit unsigned sample.
// - Unconverted channel reads as all ones.
// - Pen-up conversion reads as all ones.
// - Register write: control 00, pointer, data bytes.
// - Pointer advances after each written byte.
// - Address 0x48 or 0x49 by select pin.
module tsc_i2c_slave (
  input wire logic clock,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOeN,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic addrSel,
  input wire logic sampleBusy,
  input tsc_pkg::tsc_sample_s sample,
  output logic hostAlertN,
  output logic convHold,
  output tsc_pkg::tsc_cmd_s cmd,
  output tsc_pkg::tsc_mode_e acqMode,
  output logic [7:0] channelEnableMask
);

  logic sclS1, sclS2, sclS3;
  logic sdaS1, sdaS2, sdaS3;
  logic selS1, selS2;
  tsc_pkg::tsc_state_e state;
  tsc_pkg::tsc_phase_e phase;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] txSh;
  logic rw, wrMode, regRead, stretchOn;
  logic [5:0] ptr;
  logic [7:0] regs [tsc_pkg::REG_COUNT];
  logic [11:0] smpData [4];
  logic [3:0] smpOk;
  logic [3:0] chLeft;
  logic chHi, chRead;
  logic [2:0] convCode;
  logic [3:0] maskSet, convSet, readSet;
  logic [1:0] curCh;
  logic [15:0] chWord;
  logic [7:0] chByte, txByte;
  logic [6:0] myAddr;
  logic sclRise, sclFall, startEv, stopEv;
  logic byteDone, loadByte, cmdEv, chRdEv, releaseEv, frameSet;

  // Bus pins are asynchronous to the core clock.
  always_ff @(posedge clock) begin
    if (srst) begin
      sclS1 <= 1'h1;
      sclS2 <= 1'h1;
      sclS3 <= 1'h1;
      sdaS1 <= 1'h1;
      sdaS2 <= 1'h1;
      sdaS3 <= 1'h1;
      selS1 <= 1'h0;
      selS2 <= 1'h0;
    end else if (clkEn) begin
      sclS1 <= sclIn;
      sclS2 <= sclS1;
      sclS3 <= sclS2;
      sdaS1 <= sdaIn;
      sdaS2 <= sdaS1;
      sdaS3 <= sdaS2;
      selS1 <= addrSel;
      selS2 <= selS1;
    end
  end

  assign sclRise = sclS2 & ~sclS3;
  assign sclFall = ~sclS2 & sclS3;
  assign startEv = sclS2 & sclS3 & sdaS3 & ~sdaS2;
  assign stopEv = sclS2 & sclS3 & ~sdaS3 & sdaS2;
  assign myAddr = selS2 ? tsc_pkg::ADDR_HI : tsc_pkg::ADDR_LO;

  assign byteDone = (state == tsc_pkg::ST_RX) && sclFall && (bitCnt == tsc_pkg::BYTE_BITS);
  assign loadByte = sclFall && (((state == tsc_pkg::ST_RXACK) && (phase == tsc_pkg::PH_ADDR) && rw)
    || ((state == tsc_pkg::ST_TXACK) && (bitCnt == tsc_pkg::ACK_SEEN)));
  assign cmdEv = byteDone && (phase == tsc_pkg::PH_CTRL) && shiftIn[7];
  assign chRdEv = byteDone && (phase == tsc_pkg::PH_ADDR) && (shiftIn[7:1] == myAddr)
    && shiftIn[0] && !regRead;
  assign frameSet = sample.valid && sample.last;
  assign releaseEv = stopEv && chRead && (chLeft == 4'h0) && !hostAlertN;

  assign txByte = regRead ? regs[ptr] : chByte;
  assign sclOut = 1'h0;
  assign sdaOut = 1'h0;
  assign sclOeN = !((state == tsc_pkg::ST_RXACK) && stretchOn && sampleBusy);
  assign convHold = !hostAlertN;
  assign channelEnableMask = regs[tsc_pkg::REG_CHAN_MASK];

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= tsc_pkg::ST_IDLE;
      phase <= tsc_pkg::PH_ADDR;
      bitCnt <= 4'h0;
      shiftIn <= 8'h00;
      txSh <= 8'h00;
      rw <= 1'h0;
      wrMode <= 1'h0;
      regRead <= 1'h0;
      ptr <= 6'h00;
      sdaOeN <= 1'h1;
      stretchOn <= 1'h0;
    end else if (clkEn) begin
      if (stopEv) begin
        state <= tsc_pkg::ST_IDLE;
        regRead <= 1'h0;
        sdaOeN <= 1'h1;
        stretchOn <= 1'h0;
      end else if (startEv) begin
        // A repeated start keeps regRead so a register read can follow its pointer.
        state <= tsc_pkg::ST_RX;
        phase <= tsc_pkg::PH_ADDR;
        bitCnt <= 4'h0;
        sdaOeN <= 1'h1;
        stretchOn <= 1'h0;
      end else if (loadByte) begin
        state <= tsc_pkg::ST_TX;
        txSh <= txByte;
        sdaOeN <= txByte[7];
        bitCnt <= 4'h1;
        if (regRead) begin
          ptr <= ptr + 6'h01;
        end
      end else begin
        case (state)
          tsc_pkg::ST_RX: begin
            if (sclRise) begin
              shiftIn <= {shiftIn[6:0], sdaS2};
              bitCnt <= bitCnt + 4'h1;
            end else if (byteDone) begin
              state <= tsc_pkg::ST_RXACK;
              sdaOeN <= 1'h0;
              stretchOn <= (phase == tsc_pkg::PH_CTRL)
                || ((phase == tsc_pkg::PH_ADDR) && shiftIn[0] && !regRead);
              case (phase)
                tsc_pkg::PH_ADDR: begin
                  if (shiftIn[7:1] != myAddr) begin
                    state <= tsc_pkg::ST_IDLE;
                    sdaOeN <= 1'h1;
                    stretchOn <= 1'h0;
                  end
                  rw <= shiftIn[0];
                end
                // The pointer rides in the low bits of the control byte itself.
                tsc_pkg::PH_CTRL: begin
                  wrMode <= shiftIn[7:6] == tsc_pkg::CR_WRITE;
                  ptr <= shiftIn[5:0];
                end
                tsc_pkg::PH_DATA: begin
                  ptr <= ptr + 6'h01;
                end
                default: begin
                end
              endcase
            end
          end
          tsc_pkg::ST_RXACK: begin
            // Once the host has seen the clock high the hold must not return.
            if (sclRise) begin
              stretchOn <= 1'h0;
            end
            if (sclFall) begin
              state <= tsc_pkg::ST_RX;
              bitCnt <= 4'h0;
              sdaOeN <= 1'h1;
              case (phase)
                tsc_pkg::PH_ADDR: begin
                  phase <= tsc_pkg::PH_CTRL;
                end
                tsc_pkg::PH_CTRL: begin
                  phase <= wrMode ? tsc_pkg::PH_DATA : tsc_pkg::PH_IGN;
                  regRead <= shiftIn[7:6] == tsc_pkg::CR_READ;
                end
                default: begin
                end
              endcase
            end
          end
          tsc_pkg::ST_TX: begin
            if (sclFall) begin
              if (bitCnt == tsc_pkg::BYTE_BITS) begin
                state <= tsc_pkg::ST_TXACK;
                sdaOeN <= 1'h1;
              end else begin
                txSh <= {txSh[6:0], 1'h0};
                sdaOeN <= txSh[6];
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          tsc_pkg::ST_TXACK: begin
            if (sclRise) begin
              if (sdaS2) begin
                state <= tsc_pkg::ST_IDLE;
              end else begin
                bitCnt <= tsc_pkg::ACK_SEEN;
              end
            end
          end
          default: begin
            state <= tsc_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < tsc_pkg::REG_COUNT; i++) begin
        regs[i] <= tsc_pkg::tsc_reg_default(i);
      end
    end else if (clkEn && byteDone && (phase == tsc_pkg::PH_DATA)) begin
      regs[ptr] <= shiftIn;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cmd <= '0;
      acqMode <= tsc_pkg::MODE_MANUAL;
      convCode <= tsc_pkg::CH_X;
    end else if (clkEn) begin
      cmd.select <= 1'h0;
      cmd.convert <= 1'h0;
      if (cmdEv) begin
        case (shiftIn[7:4])
          tsc_pkg::CMD_SELECT: begin
            cmd.select <= 1'h1;
            cmd.chan <= shiftIn[2:0];
          end
          tsc_pkg::CMD_CONVERT: begin
            cmd.convert <= 1'h1;
            cmd.chan <= shiftIn[2:0];
            convCode <= shiftIn[2:0];
          end
          tsc_pkg::CMD_MAN: begin
            acqMode <= tsc_pkg::MODE_MANUAL;
          end
          tsc_pkg::CMD_PEN_DETECT_MODE_CMD: begin
            acqMode <= tsc_pkg::MODE_PEN_DETECT_MODE_CMD;
          end
          tsc_pkg::CMD_PEN_TRIGGER_MODE_CMD: begin
            acqMode <= tsc_pkg::MODE_PEN_TRIGGER_MODE_CMD;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // mask bit 7 is X, so X lands in bit 0 and is sent first.
  assign maskSet = {channelEnableMask[4], channelEnableMask[5],
    channelEnableMask[6], channelEnableMask[7]};

  always_comb begin
    if (convCode == tsc_pkg::CH_SEQ) begin
      convSet = maskSet;
    end else if (!convCode[2]) begin
      convSet = 4'h1 << convCode[1:0];
    end else begin
      convSet = 4'h0;
    end
  end

  assign readSet = (acqMode == tsc_pkg::MODE_MANUAL) ? convSet : maskSet;

  always_comb begin
    if (chLeft[0]) begin
      curCh = 2'h0;
    end else if (chLeft[1]) begin
      curCh = 2'h1;
    end else if (chLeft[2]) begin
      curCh = 2'h2;
    end else begin
      curCh = 2'h3;
    end
  end

  assign chWord = smpOk[curCh] ? {2'h0, curCh, smpData[curCh]} : tsc_pkg::INVALID_WORD;
  assign chByte = (chLeft == 4'h0) ? tsc_pkg::FILL_BYTE : (chHi ? chWord[15:8] : chWord[7:0]);

  always_ff @(posedge clock) begin
    if (srst) begin
      chLeft <= 4'h0;
      chHi <= 1'h1;
      chRead <= 1'h0;
    end else if (clkEn) begin
      if (startEv || stopEv) begin
        chRead <= 1'h0;
      end
      if (chRdEv) begin
        chRead <= 1'h1;
        chLeft <= readSet;
        chHi <= 1'h1;
      end else if (loadByte && !regRead && (chLeft != 4'h0)) begin
        chHi <= !chHi;
        if (!chHi) begin
          chLeft <= chLeft & ~(4'h1 << curCh);
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      smpOk <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        smpData[i] <= 12'h000;
      end
    end else if (clkEn) begin
      if (releaseEv) begin
        smpOk <= 4'h0;
      end
      if (sample.valid) begin
        smpData[sample.chan] <= sample.data;
        smpOk[sample.chan] <= !sample.penUp;
      end
    end
  end

  // A new frame outranks a release in the same cycle, so no frame is lost.
  always_ff @(posedge clock) begin
    if (srst) begin
      hostAlertN <= 1'h1;
    end else if (clkEn) begin
      if (frameSet) begin
        hostAlertN <= 1'h0;
      end else if (releaseEv) begin
        hostAlertN <= 1'h1;
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  addr_reject_a: assert property (
    clkEn && byteDone && (phase == tsc_pkg::PH_ADDR) && (shiftIn[7:1] != myAddr)
    |=> (state == tsc_pkg::ST_IDLE) && sdaOeN)
    else $error("Foreign address was not ignored.");

  ack_drive_a: assert property (
    (state == tsc_pkg::ST_RXACK) |-> !sdaOeN)
    else $error("Received byte not acknowledged.");

  rd_ptr_a: assert property (
    clkEn && loadByte && regRead |=> ptr == $past(ptr) + 6'h01)
    else $error("Read pointer did not advance.");

  wr_ptr_a: assert property (
    clkEn && byteDone && (phase == tsc_pkg::PH_DATA) |=> ptr == $past(ptr) + 6'h01)
    else $error("Write pointer did not advance.");

  stretch_hold_a: assert property (
    clkEn && byteDone && (phase == tsc_pkg::PH_CTRL) ##1 sampleBusy |-> !sclOeN)
    else $error("Clock not held after command byte.");

  alert_release_a: assert property (
    clkEn && releaseEv && !frameSet |=> hostAlertN && !convHold)
    else $error("Alert not released after last data.");

  conv_suspend_a: assert property (
    clkEn && frameSet |=> convHold && !hostAlertN)
    else $error("Converter not suspended with data pending.");

  mode_entry_a: assert property (
    clkEn && cmdEv && (shiftIn[7:4] == tsc_pkg::CMD_PEN_DETECT_MODE_CMD) |=> acqMode == tsc_pkg::MODE_PEN_DETECT_MODE_CMD)
    else $error("Pen detect mode not entered.");

  cmd_ignore_a: assert property (
    clkEn && cmdEv && (shiftIn[7:4] == 4'hf) |=> $stable(acqMode) && !cmd.select && !cmd.convert)
    else $error("Unknown command changed state.");

  fill_byte_a: assert property (
    clkEn && loadByte && !regRead && (chLeft == 4'h0) |=> txSh == tsc_pkg::FILL_BYTE)
    else $error("Exhausted channel read not all ones.");

  tag_byte_a: assert property (
    clkEn && loadByte && !regRead && chHi && (chLeft != 4'h0) && smpOk[curCh]
    |=> txSh[7:4] == {2'h0, $past(curCh)})
    else $error("Channel tag wrong in high byte.");

endmodule

// *** tsc_i2c_host.sv ***
module tsc_i2c_host (
  input wire logic clock,
  input wire logic sclLine,
  input wire logic sdaLine,
  output logic sclLow,
  output logic sdaLow,
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    hung = 1'b0;
  end

  task automatic hold();
    repeat (4) @(posedge clock);
  endtask

  // SDA moves one clock after SCL falls, so the slave never sees it change while SCL is high.
  task automatic bitXfer(input logic b, output logic r);
    int n;
    n = 0;
    @(posedge clock);
    sdaLow <= !b;
    // Four clocks per SCL level give the 80 ns bit period.
    repeat (3) @(posedge clock);
    sclLow <= 1'b0;
    while (sclLine !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n == 3000) begin
      hung <= 1'b1;
    end
    repeat (3) @(posedge clock);
    @(negedge clock);
    r = sdaLine;
    @(posedge clock);
    sclLow <= 1'b1;
  endtask

  task automatic startCond();
    @(posedge clock);
    sdaLow <= 1'b0;
    hold();
    hold();
    sclLow <= 1'b0;
    hold();
    sdaLow <= 1'b1;
    hold();
    sclLow <= 1'b1;
  endtask

  task automatic stopCond();
    @(posedge clock);
    sdaLow <= 1'b1;
    hold();
    sclLow <= 1'b0;
    hold();
    sdaLow <= 1'b0;
    hold();
  endtask

  task automatic writeByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitXfer(b[i], r);
    end
    bitXfer(1'b1, r);
    ack = !r;
  endtask

  task automatic readByte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitXfer(1'b1, r);
      b[i] = r;
    end
    bitXfer(!more, r);
  endtask
endmodule

// *** tsc_i2c_slave_tb.sv ***
module tsc_i2c_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 40000;
  logic clock = 1'b0;
  logic srst, clkEn, addrSel, sampleBusy, hostAlertN, convHold, sclOut, sclOeN;
  logic sdaOut, sdaOeN, sclLow, sdaLow, hung, sclLine, sdaLine;
  tsc_pkg::tsc_sample_s sample;
  tsc_pkg::tsc_cmd_s cmd;
  tsc_pkg::tsc_mode_e acqMode;
  logic [7:0] channelEnableMask;
  logic [7:0] regModel [64];
  logic [1:0] lastPulse = 2'h0;
  logic [6:0] dev = tsc_pkg::ADDR_LO;
  logic [6:0] alist [3] = '{7'h48, 7'h49, 7'h00};
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  int fails = 0, tests_run = 0, cycles = 0, stretchCnt = 0, r, k, j;
  integer seed = 32'h440e;
  logic ack;

  always #5 clock = ~clock;
  // Both lines have pull-ups; either party pulling low wins.
  assign sclLine = (sclLow || sclOeN === 1'b0) ? 1'b0 : 1'b1;
  assign sdaLine = (sdaLow || sdaOeN === 1'b0) ? 1'b0 : 1'b1;

  tsc_i2c_slave DUT (.clock(clock), .srst(srst), .clkEn(clkEn), .sclIn(sclLine),
    .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .addrSel(addrSel), .sampleBusy(sampleBusy), .sample(sample), .hostAlertN(hostAlertN),
    .convHold(convHold), .cmd(cmd), .acqMode(acqMode), .channelEnableMask(channelEnableMask));
  tsc_i2c_host host (.clock(clock), .sclLine(sclLine), .sdaLine(sdaLine), .sclLow(sclLow),
    .sdaLow(sdaLow), .hung(hung));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (sclOeN === 1'b0) begin
      stretchCnt <= stretchCnt + 1;
    end
    if (cmd.select === 1'b1 || cmd.convert === 1'b1) begin
      lastPulse <= {cmd.select, cmd.convert};
    end
    if (cycles == LIMIT) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk1(input string name, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic addrPh(input logic [6:0] a, input logic rd, output logic a0);
    host.startCond();
    host.writeByte({a, rd}, a0);
  endtask

  task automatic finish();
    host.stopCond();
    repeat (10) @(posedge clock);
  endtask

  // Keeps the converter busy until the slave has stretched SCL for a while.
  task automatic busyWin();
    for (int i = 0; i < 3000 && stretchCnt < 20; i++) begin
      @(posedge clock);
    end
    sampleBusy <= 1'b0;
  endtask

  task automatic regWrite(input logic [5:0] p, input int n, input logic [7:0] first);
    logic [7:0] d;
    int x;
    addrPh(dev, 1'b0, ack);
    chk1("addr ack", 1'b1, ack);
    host.writeByte({tsc_pkg::CR_WRITE, p}, ack);
    chk1("ctrl ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      x = $random(seed);
      d = (i == 0) ? first : x[7:0];
      host.writeByte(d, ack);
      chk1("data ack", 1'b1, ack);
      regModel[p + i[5:0]] = d;
    end
    finish();
  endtask

  task automatic regRead(input logic [5:0] p, input int n);
    logic [7:0] d;
    addrPh(dev, 1'b0, ack);
    chk1("addr ack", 1'b1, ack);
    host.writeByte({tsc_pkg::CR_READ, p}, ack);
    chk1("ptr ack", 1'b1, ack);
    addrPh(dev, 1'b1, ack);
    chk1("read ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      host.readByte(i < n - 1, d);
      chk8("reg byte", regModel[p + i[5:0]], d);
    end
    finish();
  endtask

  task automatic cmdSend(input logic [7:0] c, input logic busy);
    stretchCnt = 0;
    sampleBusy <= busy;
    fork
      begin
        addrPh(dev, 1'b0, ack);
        host.writeByte(c, ack);
      end
      if (busy) busyWin();
    join
    chk1("cmd ack", 1'b1, ack);
    finish();
    if (busy) chk1("stretch", 1'b1, stretchCnt >= 20);
  endtask

  // A channel flagged in miss gets no sample at all, so it must read as invalid.
  task automatic chanCase(input logic [7:0] set, input logic [3:0] pu, input logic [3:0] miss,
    input logic busy);
    logic [7:0] d;
    logic [15:0] w;
    logic [7:0] q [$];
    int lastC;
    lastC = 0;
    for (int i = 0; i < 4; i++) begin
      if (set[7 - i] && !miss[i]) lastC = i;
    end
    for (int i = 0; i < 4; i++) begin
      if (set[7 - i]) begin
        r = $random(seed);
        if (!miss[i]) begin
          @(posedge clock);
          sample <= {1'b1, i == lastC, i[1:0], pu[i], r[11:0]};
          @(posedge clock);
          sample <= '0;
        end
        w = (pu[i] || miss[i]) ? tsc_pkg::INVALID_WORD : {2'b00, i[1:0], r[11:0]};
        q.push_back(w[15:8]);
        q.push_back(w[7:0]);
      end
    end
    while (q.size() < 10) q.push_back(tsc_pkg::FILL_BYTE);
    repeat (4) @(posedge clock);
    chk1("alert low", 1'b0, hostAlertN);
    chk1("hold on", 1'b1, convHold);
    stretchCnt = 0;
    sampleBusy <= busy;
    fork
      addrPh(dev, 1'b1, ack);
      if (busy) busyWin();
    join
    chk1("chan ack", 1'b1, ack);
    if (busy) chk1("stretch", 1'b1, stretchCnt >= 20);
    for (int i = 0; i < 10; i++) begin
      host.readByte(i < 9, d);
      chk8("chan byte", q[i], d);
    end
    finish();
    chk1("alert high", 1'b1, hostAlertN);
    chk1("hold off", 1'b0, convHold);
  endtask

  initial begin
    srst = 1'b1;
    clkEn = 1'b1;
    addrSel = 1'b0;
    sampleBusy = 1'b0;
    sample = '0;
    for (int i = 0; i < 64; i++) regModel[i] = 8'h00;
    regModel[1] = 8'h20;
    regModel[4] = 8'hc0;
    regModel[8] = 8'h80;
    regModel[32] = 8'h01;
    regModel[34] = 8'h08;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    repeat (5) @(posedge clock);
    chk1("alert", 1'b1, hostAlertN);
    chk8("mask", 8'hc0, channelEnableMask);
    chk8("mode", 8'h00, {6'h00, acqMode});
    chk8("cmd", 8'h00, {3'h0, cmd});
    chk1("scl out", 1'b0, sclOut);
    chk1("sda out", 1'b0, sdaOut);
    for (k = 0; k < 2; k++) begin
      addrSel <= k[0];
      repeat (8) @(posedge clock);
      for (j = 0; j < 3; j++) begin
        addrPh(alist[j], 1'b0, ack);
        finish();
        chk1("addr", alist[j] == {6'h24, k[0]}, ack);
      end
    end
    dev = tsc_pkg::ADDR_HI;
    regRead(6'h00, 4);
    regRead(6'h3f, 3);
    r = $random(seed);
    regWrite(6'h04, 3, r[7:0]);
    chk8("mask", regModel[4], channelEnableMask);
    regRead(6'h03, 5);
    for (k = 0; k < 5; k++) begin
      r = $random(seed);
      cmdSend({3'b101, k[0], r[0], codes[k]}, 1'b0);
      chk8("pulse", {6'h00, k[0] ? 2'b01 : 2'b10}, {6'h00, lastPulse});
      chk8("chan", {5'h00, codes[k]}, {5'h00, cmd.chan});
    end
    for (k = 0; k < 3; k++) begin
      r = $random(seed);
      cmdSend({tsc_pkg::CMD_MAN + k[3:0], r[3:0]}, k == 1);
      chk8("mode", {6'h00, k[1:0]}, {6'h00, acqMode});
    end
    cmdSend(8'h85, 1'b0);
    cmdSend(8'hf3, 1'b0);
    chk8("mode", 8'h02, {6'h00, acqMode});
    chk8("chan", 8'h07, {5'h00, cmd.chan});
    regWrite(6'h04, 1, 8'hc0);
    chanCase(8'hc0, 4'h0, 4'h0, 1'b0);
    regWrite(6'h04, 1, 8'hf0);
    chanCase(8'hf0, 4'h4, 4'h0, 1'b1);
    regWrite(6'h04, 1, 8'h60);
    chanCase(8'h60, 4'h0, 4'h4, 1'b0);
    cmdSend(8'hc5, 1'b0);
    cmdSend(8'hb8, 1'b0);
    chanCase(8'h80, 4'h0, 4'h0, 1'b0);
    chk1("host wait", 1'b0, hung);
    end_sim();
  end
endmodule
